/* logic/iau_consts.svh */
// Constants of the interrupt aggregation unit: register indices, field
// positions, reset values and widths.
// Assumes APB with 32-bit data; byte address equals four times the index.
`ifndef IAU_CONSTS_SVH
`define IAU_CONSTS_SVH

// ****************************************************************
// Bus geometry
// ****************************************************************
`define IAU_AW              18
`define IAU_IW              16

// ****************************************************************
// Register indices (byte address is index times four)
// ****************************************************************
`define IAU_IDX_DRV0_OUT    16'hFC20
`define IAU_IDX_DRV0_IN     16'hFC21
`define IAU_IDX_DRV0_CSR    16'hFC22
`define IAU_IDX_DRV1_OUT    16'hFC28
`define IAU_IDX_DRV1_IN     16'hFC29
`define IAU_IDX_DRV1_CSR    16'hFC2A
`define IAU_IDX_SER0_CTL    16'hFD00
`define IAU_IDX_SER0_STAT   16'hFD01
`define IAU_IDX_SER1_CTL    16'hFD02
`define IAU_IDX_SER1_STAT   16'hFD03
`define IAU_IDX_ISR         16'hFE04
`define IAU_IDX_IMR         16'hFE0D
`define IAU_IDX_IDR         16'hFE0E
`define IAU_IDX_SRCSEL      16'hFE0F
`define IAU_IDX_GPI         16'hFE10

// ****************************************************************
// Field positions
// ****************************************************************
`define IAU_CSR_RDREQ       0
`define IAU_CSR_WRREQ       1
`define IAU_SER_SLAVE       2
`define IAU_SER_BYTE        3
`define IAU_SER_BUSERR      4
`define IAU_SER_PENDN       7
`define IAU_SER_IE          3
`define IAU_ISR_SCSI        7
`define IAU_ISR_SER0        6
`define IAU_ISR_SER1        5
`define IAU_ISR_DMA         4
`define IAU_ISR_TMR2        3
`define IAU_ISR_TMR1        2

// ****************************************************************
// Reset values
// ****************************************************************
`define IAU_RST_IMR         8'h00
`define IAU_RST_IDR         8'h00
`define IAU_RST_SER_STAT    8'h80

`endif

/* logic/iau_drive_port.sv */
// Drive-side byte port: request flags, incoming and outgoing data.
// Assumes drive pins are asynchronous; software strobes are on clk.
`timescale 1ns/1ps
`include "iau_consts.svh"

module iau_drive_port
  import iau_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       rd_req_pin,
  input  wire logic       wr_stb_pin,
  input  wire logic [7:0] wr_data_pin,
  input  wire logic       out_we,
  input  wire logic [7:0] out_wdata,
  input  wire logic       csr_we,
  input  wire logic [1:0] csr_wdata,
  output logic      [1:0] csr,
  output logic      [7:0] in_data,
  output logic      [7:0] out_data,
  output logic            out_valid
);

  iau_drv_st_t st_q;
  iau_drv_st_t st_d;
  logic        rd_rise;
  logic        wr_rise;

  // ****************************************************************
  // Next state
  // ****************************************************************
  // Edges are taken from stages two and three only, never stage one.
  always_comb begin
    st_d = st_q;
    st_d.rd_sy = {st_q.rd_sy[1:0], rd_req_pin};
    st_d.wr_sy = {st_q.wr_sy[1:0], wr_stb_pin};
    st_d.dat_s1 = wr_data_pin;
    st_d.dat_s2 = st_q.dat_s1;
    rd_rise = st_q.rd_sy[1] & ~st_q.rd_sy[2];
    wr_rise = st_q.wr_sy[1] & ~st_q.wr_sy[2];
    // Write one to clear; a new request in the same cycle wins.
    if (csr_we) begin
      st_d.csr = st_q.csr & ~csr_wdata;
    end
    if (rd_rise) begin
      st_d.csr[`IAU_CSR_RDREQ] = 1'b1;
    end
    if (wr_rise) begin
      st_d.csr[`IAU_CSR_WRREQ] = 1'b1;
      st_d.in_data = st_q.dat_s2;
    end
    st_d.out_valid = out_we;
    if (out_we) begin
      st_d.out_data = out_wdata;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign csr       = st_q.csr;
  assign in_data   = st_q.in_data;
  assign out_data  = st_q.out_data;
  assign out_valid = st_q.out_valid;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  AST_DRV_RDREQ: assert property (rd_rise |=> csr[`IAU_CSR_RDREQ])
    else $error("read request did not set its flag");
  AST_DRV_WRREQ: assert property (wr_rise |=> csr[`IAU_CSR_WRREQ]
      && in_data == $past(st_q.dat_s2))
    else $error("write request did not set flag and data");

endmodule : iau_drive_port

/* logic/iau_pkg.sv */
// Types of the interrupt aggregation unit: one state struct per module.
// Assumes the constants header is included by every user.
package iau_pkg;

  // Drive-side byte port state.
  typedef struct packed {
    logic [2:0] rd_sy;
    logic [2:0] wr_sy;
    logic [7:0] dat_s1;
    logic [7:0] dat_s2;
    logic [1:0] csr;
    logic [7:0] in_data;
    logic [7:0] out_data;
    logic       out_valid;
  } iau_drv_st_t;

  // Two-wire interrupt state.
  typedef struct packed {
    logic [7:0] status;
    logic       irq;
  } iau_ser_st_t;

  // Top-level state.
  typedef struct packed {
    logic [1:0]  ext_s1;
    logic [1:0]  ext_s2;
    logic [7:0]  frc;
    logic [7:0]  mask;
    logic [7:0]  route;
    logic [1:0]  srcsel;
    logic [1:0]  ser_ie;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    logic        irq0;
    logic        irq1;
  } iau_top_st_t;

endpackage : iau_pkg

/* logic/iau_serial_irq.sv */
// Two-wire port interrupt logic: cause bits, pending flag, output.
// Assumes the event inputs are one-cycle pulses on clk.
`timescale 1ns/1ps
`include "iau_consts.svh"

module iau_serial_irq
  import iau_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       byte_done,
  input  wire logic       bus_err,
  input  wire logic       slave_hit,
  input  wire logic       ie,
  input  wire logic       stat_we,
  input  wire logic [7:0] stat_wdata,
  output logic      [7:0] status,
  output logic            irq
);

  iau_ser_st_t st_q;
  iau_ser_st_t st_d;

  // ****************************************************************
  // Next state
  // ****************************************************************
  // Writing one to the pending bit releases the port and its causes;
  // an event in that same cycle re-arms it, so nothing is lost.
  always_comb begin
    st_d = st_q;
    if (stat_we && stat_wdata[`IAU_SER_PENDN]) begin
      st_d.status = `IAU_RST_SER_STAT;
    end
    if (byte_done) begin
      st_d.status[`IAU_SER_BYTE] = 1'b1;
    end
    if (bus_err) begin
      st_d.status[`IAU_SER_BUSERR] = 1'b1;
    end
    if (slave_hit) begin
      st_d.status[`IAU_SER_SLAVE] = 1'b1;
    end
    if (byte_done | bus_err | slave_hit) begin
      st_d.status[`IAU_SER_PENDN] = 1'b0;
    end
    st_d.irq = ie & ~st_d.status[`IAU_SER_PENDN];
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_q <= '{status: `IAU_RST_SER_STAT, irq: 1'b0};
    end else begin
      st_q <= st_d;
    end
  end

  assign status = st_q.status;
  assign irq    = st_q.irq;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  AST_SER_PEND: assert property (byte_done |=> !status[7] && status[3])
    else $error("byte done did not make the port pending");
  AST_SER_ERR: assert property (bus_err |=> status[4])
    else $error("bus error not flagged");
  AST_SER_IRQ: assert property (irq |-> !status[7] && $past(ie))
    else $error("interrupt driven without enable and pending");

endmodule : iau_serial_irq

/* logic/iau_top.sv */
// Interrupt aggregation unit: collects source requests into a status
// register, masks and routes them onto two processor interrupt lines.
// Assumes an APB master on clk; drive and external pins are asynchronous;
// SCSI, DMA, timer and two-wire events come from logic on clk.
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ps
`include "iau_consts.svh"

module iau_top
  import iau_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             nrst,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [`IAU_AW-1:0] paddr,
  input  wire logic [31:0]      pwdata,
  output logic      [31:0]      prdata,
  output logic                  pready,
  output logic                  pslverr,
  input  wire logic             scsi_irq,
  input  wire logic             dma_irq,
  input  wire logic             tmr1_irq,
  input  wire logic             tmr2_irq,
  input  wire logic [1:0]       ser_byte_done,
  input  wire logic [1:0]       ser_bus_err,
  input  wire logic [1:0]       ser_slave_hit,
  input  wire logic [1:0]       ext_irq_pins,
  input  wire logic [1:0]       drv_rd_req,
  input  wire logic [1:0]       drv_wr_stb,
  input  wire logic [15:0]      drv_wr_data,
  output logic      [15:0]      drv_out_data,
  output logic      [1:0]       drv_out_valid,
  output logic                  cpu_irq0,
  output logic                  cpu_irq1
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  iau_top_st_t      st_q;
  iau_top_st_t      st_d;
  logic [`IAU_IW-1:0] idx;
  logic             setup;
  logic             wr_acc;
  logic [7:0]       interrupt_source_status;
  logic [7:0]       live;
  logic [7:0]       rd8;
  logic             hit;
  logic [1:0]       drv_out_we;
  logic [1:0]       drv_csr_we;
  logic [1:0]       ser_stat_we;
  logic [1:0]       drv_csr  [2];
  logic [7:0]       drv_in   [2];
  logic [7:0]       ser_stat [2];
  logic [1:0]       ser_irq;
  logic [`IAU_IW-1:0] idx_out  [2];
  logic [`IAU_IW-1:0] idx_in   [2];
  logic [`IAU_IW-1:0] idx_csr  [2];
  logic [`IAU_IW-1:0] idx_sctl [2];
  logic [`IAU_IW-1:0] idx_sst  [2];

  assign idx_out  = '{`IAU_IDX_DRV0_OUT,  `IAU_IDX_DRV1_OUT};
  assign idx_in   = '{`IAU_IDX_DRV0_IN,   `IAU_IDX_DRV1_IN};
  assign idx_csr  = '{`IAU_IDX_DRV0_CSR,  `IAU_IDX_DRV1_CSR};
  assign idx_sctl = '{`IAU_IDX_SER0_CTL,  `IAU_IDX_SER1_CTL};
  assign idx_sst  = '{`IAU_IDX_SER0_STAT, `IAU_IDX_SER1_STAT};

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  // Writes land only at the access edge where pready is already high.
  assign idx    = paddr[`IAU_AW-1:2];
  assign setup  = psel & ~penable & ~st_q.pready;
  assign wr_acc = psel & penable & pwrite & st_q.pready;

  // ****************************************************************
  // Per-port sources
  // ****************************************************************
  // Both drive ports and both two-wire ports repeat the same wiring.
  for (genvar p = 0; p < 2; p++) begin : g_port
    assign drv_out_we[p]  = wr_acc && idx == idx_out[p];
    assign drv_csr_we[p]  = wr_acc && idx == idx_csr[p];
    assign ser_stat_we[p] = wr_acc && idx == idx_sst[p];

    iau_drive_port u_drv (
      .clk         (clk),
      .nrst        (nrst),
      .rd_req_pin  (drv_rd_req[p]),
      .wr_stb_pin  (drv_wr_stb[p]),
      .wr_data_pin (drv_wr_data[8*p +: 8]),
      .out_we      (drv_out_we[p]),
      .out_wdata   (pwdata[7:0]),
      .csr_we      (drv_csr_we[p]),
      .csr_wdata   (pwdata[1:0]),
      .csr         (drv_csr[p]),
      .in_data     (drv_in[p]),
      .out_data    (drv_out_data[8*p +: 8]),
      .out_valid   (drv_out_valid[p])
    );

    iau_serial_irq u_ser (
      .clk         (clk),
      .nrst        (nrst),
      .byte_done   (ser_byte_done[p]),
      .bus_err     (ser_bus_err[p]),
      .slave_hit   (ser_slave_hit[p]),
      .ie          (st_q.ser_ie[p]),
      .stat_we     (ser_stat_we[p]),
      .stat_wdata  (pwdata[7:0]),
      .status      (ser_stat[p]),
      .irq         (ser_irq[p])
    );

    // Low two bits pick drive port or external pin per source select.
    assign live[p] = st_q.srcsel[p] ? st_q.ext_s2[p] : |drv_csr[p];
  end

  // ****************************************************************
  // Status composition
  // ****************************************************************
  // Status follows its sources, so it clears only when the source does;
  // the force bits stay until software writes them back to zero.
  assign live[`IAU_ISR_SCSI] = scsi_irq;
  assign live[`IAU_ISR_DMA]  = dma_irq;
  assign live[`IAU_ISR_SER0] = ser_irq[0];
  assign live[`IAU_ISR_SER1] = ser_irq[1];
  assign live[`IAU_ISR_TMR2] = tmr2_irq;
  assign live[`IAU_ISR_TMR1] = tmr1_irq;
  assign interrupt_source_status = live | st_q.frc;

  // ****************************************************************
  // Read mux
  // ****************************************************************
  // Narrow registers sit in the low byte; upper bits read as zero.
  always_comb begin
    rd8 = 8'h00;
    hit = 1'b1;
    case (idx)
      `IAU_IDX_DRV0_OUT:  rd8 = drv_out_data[7:0];
      `IAU_IDX_DRV0_IN:   rd8 = drv_in[0];
      `IAU_IDX_DRV0_CSR:  rd8 = {6'h00, drv_csr[0]};
      `IAU_IDX_DRV1_OUT:  rd8 = drv_out_data[15:8];
      `IAU_IDX_DRV1_IN:   rd8 = drv_in[1];
      `IAU_IDX_DRV1_CSR:  rd8 = {6'h00, drv_csr[1]};
      `IAU_IDX_SER0_CTL:  rd8 = {4'h0, st_q.ser_ie[0], 3'h0};
      `IAU_IDX_SER0_STAT: rd8 = ser_stat[0];
      `IAU_IDX_SER1_CTL:  rd8 = {4'h0, st_q.ser_ie[1], 3'h0};
      `IAU_IDX_SER1_STAT: rd8 = ser_stat[1];
      `IAU_IDX_ISR:       rd8 = interrupt_source_status;
      `IAU_IDX_IMR:       rd8 = st_q.mask;
      `IAU_IDX_IDR:       rd8 = st_q.route;
      `IAU_IDX_SRCSEL:    rd8 = {6'h00, st_q.srcsel};
      `IAU_IDX_GPI:       rd8 = {6'h00, st_q.ext_s2};
      default:            hit = 1'b0;
    endcase
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  // The answer is registered in the setup cycle, so every access takes
  // exactly one access-phase cycle and all outputs leave flip-flops.
  always_comb begin
    st_d = st_q;
    st_d.ext_s1 = ext_irq_pins;
    st_d.ext_s2 = st_q.ext_s1;
    st_d.pready = setup;
    if (setup) begin
      st_d.prdata  = pwrite ? 32'h0000_0000 : {24'h00_0000, rd8};
      st_d.pslverr = ~hit;
    end else begin
      st_d.prdata  = 32'h0000_0000;
      st_d.pslverr = 1'b0;
    end
    if (wr_acc) begin
      case (idx)
        `IAU_IDX_ISR:      st_d.frc = pwdata[7:0];
        `IAU_IDX_IMR:      st_d.mask = pwdata[7:0];
        `IAU_IDX_IDR:      st_d.route = pwdata[7:0];
        `IAU_IDX_SRCSEL:   st_d.srcsel = pwdata[1:0];
        `IAU_IDX_SER0_CTL: st_d.ser_ie[0] = pwdata[`IAU_SER_IE];
        `IAU_IDX_SER1_CTL: st_d.ser_ie[1] = pwdata[`IAU_SER_IE];
        default:           st_d.frc = st_q.frc;
      endcase
    end
    // Masked bits never reach a line; the route bit picks the line.
    st_d.irq0 = |(interrupt_source_status & st_q.mask & ~st_q.route);
    st_d.irq1 = |(interrupt_source_status & st_q.mask & st_q.route);
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_q       <= '0;
      st_q.mask  <= `IAU_RST_IMR;
      st_q.route <= `IAU_RST_IDR;
    end else begin
      st_q <= st_d;
    end
  end

  assign prdata   = st_q.prdata;
  assign pready   = st_q.pready;
  assign pslverr  = st_q.pslverr;
  assign cpu_irq0 = st_q.irq0;
  assign cpu_irq1 = st_q.irq1;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  AST_MASKED: assert property ((interrupt_source_status & st_q.mask) == 8'h00
      |=> !cpu_irq0 && !cpu_irq1)
    else $error("masked status reached an interrupt line");
  AST_ROUTE1: assert property ((interrupt_source_status & st_q.mask & st_q.route) != 8'h00
      |=> cpu_irq1)
    else $error("routed status did not raise line one");
  AST_ROUTE0: assert property ((interrupt_source_status & st_q.mask & ~st_q.route) != 8'h00
      |=> cpu_irq0)
    else $error("unmasked status did not raise line zero");
  AST_FORCE: assert property (wr_acc && idx == `IAU_IDX_ISR
      |=> (interrupt_source_status & $past(pwdata[7:0])) == $past(pwdata[7:0]))
    else $error("forced status bit not seen");
  AST_SCSI_DMA: assert property (st_q.frc == 8'h00
      |-> interrupt_source_status[7] == scsi_irq && interrupt_source_status[4] == dma_irq)
    else $error("SCSI or DMA status bit misplaced");
  AST_APB_ONE_WAIT: assert property (setup |=> pready ##1 !pready)
    else $error("slave answer not exactly one cycle");
  AST_MASK_RESET: assert property ($rose(nrst) |-> st_q.mask == 8'h00)
    else $error("mask not cleared by reset");
  AST_LINE_RESET: assert property ($rose(nrst)
      |-> !cpu_irq0 && !cpu_irq1)
    else $error("interrupt line high straight after reset");

  // With nothing unmasked and routed, a line must drop; together with
  // the raise checks above this pins each line to its OR of status.
  AST_LN0_LOW: assert property ((interrupt_source_status & st_q.mask & ~st_q.route) == 8'h00
      |=> !cpu_irq0)
    else $error("line zero high with no routed status");
  AST_LN1_LOW: assert property ((interrupt_source_status & st_q.mask & st_q.route) == 8'h00
      |=> !cpu_irq1)
    else $error("line one high with no routed status");

  // Each fixed source sits on its own status bit while nothing is forced.
  AST_SER_BITS: assert property (st_q.frc == 8'h00
      |-> interrupt_source_status[6] == ser_irq[0] && interrupt_source_status[5] == ser_irq[1])
    else $error("two-wire status bit misplaced");
  AST_TMR_BITS: assert property (st_q.frc == 8'h00
      |-> interrupt_source_status[3] == tmr2_irq && interrupt_source_status[2] == tmr1_irq)
    else $error("timer status bit misplaced");

  // The two low bits follow the drive ports or the pins, per select.
  AST_DRV_BITS: assert property (st_q.srcsel == 2'h0
      && st_q.frc[1:0] == 2'h0
      |-> interrupt_source_status[1:0] == {|drv_csr[1], |drv_csr[0]})
    else $error("drive port request not on its status bit");
  AST_PIN_BITS: assert property (st_q.srcsel[0]
      && !st_q.frc[0] |-> interrupt_source_status[0] == st_q.ext_s2[0])
    else $error("external pin not on its status bit");

  // Between answers the bus outputs rest at zero, so a master that
  // samples late can never pick up a stale word or a stale error.
  AST_APB_IDLE: assert property (!pready
      |-> prdata == 32'h0000_0000 && !pslverr)
    else $error("read data or error shown outside an answer");
  AST_APB_UPPER: assert property (pready |-> prdata[31:8] == 24'h00_0000)
    else $error("upper read data bits not zero");
  AST_APB_MISS: assert property (setup && !hit |=> pslverr)
    else $error("unmapped index not refused");

  // A write lands exactly at the access edge and nowhere else.
  AST_IMR_WR: assert property (wr_acc && idx == `IAU_IDX_IMR
      |=> st_q.mask == $past(pwdata[7:0]))
    else $error("mask write did not land");
  AST_IDR_WR: assert property (wr_acc && idx == `IAU_IDX_IDR
      |=> st_q.route == $past(pwdata[7:0]))
    else $error("route write did not land");
  AST_SRC_WR: assert property (wr_acc && idx == `IAU_IDX_SRCSEL
      |=> st_q.srcsel == $past(pwdata[1:0]))
    else $error("source select write did not land");

endmodule : iau_top

/* testbench/iau_cpu_model.sv */
// Model of the processor's two level-sensitive interrupt inputs.
// Assumes both lines are registers on clk; ack clears the latched view.
`timescale 1ns/1ps

module iau_cpu_model (
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       cpu_irq0,
  input  wire logic       cpu_irq1,
  input  wire logic       ack,
  output logic      [1:0] seen
);
  // ****************************************************************
  // Interrupt input latch
  // ****************************************************************
  // The core samples levels, so a short gap in a line loses nothing.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      seen <= 2'h0;
    end else if (ack) begin
      seen <= 2'h0;
    end else begin
      seen <= seen | {cpu_irq1, cpu_irq0};
    end
  end
endmodule : iau_cpu_model

/* testbench/iau_top_tb.sv */
// Self-checking bench of the interrupt aggregation unit.
// Assumes the constants header is on the include path.
`timescale 1ns/1ps
`include "iau_consts.svh"

module iau_top_tb;
  // ****************************************************************
  // Stimulus and wiring
  // ****************************************************************
  logic              clk = 1'b0;
  logic              nrst = 1'b0;
  logic              psel = 1'b0, penable = 1'b0, pwrite = 1'b0, ack = 1'b0;
  logic [`IAU_AW-1:0] paddr = '0;
  logic [31:0]       pwdata = 32'h0, prdata, rd;
  logic              pready, pslverr, cpu_irq0, cpu_irq1, err;
  logic              scsi_irq = 1'b0, dma_irq = 1'b0;
  logic              tmr1_irq = 1'b0, tmr2_irq = 1'b0;
  logic [1:0]        ser_byte_done = 2'h0, ser_bus_err = 2'h0;
  logic [1:0]        ser_slave_hit = 2'h0, ext_irq_pins = 2'h0;
  logic [1:0]        drv_rd_req = 2'h0, drv_wr_stb = 2'h0;
  logic [15:0]       drv_wr_data = 16'h0, drv_out_data;
  logic [1:0]        drv_out_valid, seen;
  int                n_fail = 0, tests_run = 0;
  // Sources {scsi,dma,tmr2,tmr1}, mask, route, status, lines {1,0}.
  logic [29:0]       rows [4] = '{
    {4'h8, 8'h80, 8'h00, 8'h80, 2'h1},
    {4'h4, 8'h10, 8'h10, 8'h10, 2'h2},
    {4'h2, 8'h00, 8'h00, 8'h08, 2'h0},
    {4'h1, 8'h04, 8'hFF, 8'h04, 2'h2}};

  iau_top i_iau_top (.clk(clk), .nrst(nrst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .scsi_irq(scsi_irq), .dma_irq(dma_irq), .tmr1_irq(tmr1_irq),
    .tmr2_irq(tmr2_irq), .ser_byte_done(ser_byte_done),
    .ser_bus_err(ser_bus_err), .ser_slave_hit(ser_slave_hit),
    .ext_irq_pins(ext_irq_pins), .drv_rd_req(drv_rd_req),
    .drv_wr_stb(drv_wr_stb), .drv_wr_data(drv_wr_data),
    .drv_out_data(drv_out_data), .drv_out_valid(drv_out_valid),
    .cpu_irq0(cpu_irq0), .cpu_irq1(cpu_irq1));

  iau_cpu_model i_iau_cpu_model (.clk(clk), .nrst(nrst),
    .cpu_irq0(cpu_irq0), .cpu_irq1(cpu_irq1), .ack(ack), .seen(seen));

  always #5 clk = ~clk;

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic end_sim;
    $display("Checks %0d, mismatches %0d.", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      n_fail++;
    end
  endtask : chk

  // One APB transfer; entered just after a rising edge, ends after one.
  task automatic apb(input logic w, input logic [15:0] idx,
                     input logic [7:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'h0};
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    if (pready !== 1'b1) begin
      n_fail++;
      end_sim();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  task automatic rdc(input logic [15:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    chk(rd, {24'h0, exp});
  endtask : rdc

  // ****************************************************************
  // Sequence
  // ****************************************************************
  initial begin
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    rdc(`IAU_IDX_IMR, `IAU_RST_IMR);
    rdc(`IAU_IDX_IDR, 8'h00);
    rdc(`IAU_IDX_SER0_STAT, 8'h80);
    foreach (rows[i]) begin
      {scsi_irq, dma_irq, tmr2_irq, tmr1_irq} <= rows[i][29:26];
      apb(1'b1, `IAU_IDX_IMR, rows[i][25:18]);
      apb(1'b1, `IAU_IDX_IDR, rows[i][17:10]);
      ack <= 1'b1;
      @(posedge clk);
      ack <= 1'b0;
      repeat (3) @(posedge clk);
      rdc(`IAU_IDX_ISR, rows[i][9:2]);
      chk({30'h0, cpu_irq1, cpu_irq0}, {30'h0, rows[i][1:0]});
      chk({30'h0, seen}, {30'h0, rows[i][1:0]});
    end
    // Forced bits must reach the lines like real sources.
    {scsi_irq, dma_irq, tmr2_irq, tmr1_irq} <= 4'h0;
    apb(1'b1, `IAU_IDX_IMR, 8'hFF);
    apb(1'b1, `IAU_IDX_IDR, 8'h02);
    apb(1'b1, `IAU_IDX_ISR, 8'h03);
    rdc(`IAU_IDX_ISR, 8'h03);
    chk({30'h0, cpu_irq1, cpu_irq0}, 32'h3);
    apb(1'b1, `IAU_IDX_ISR, 8'h00);
    apb(1'b0, 16'h0000, 8'h00);
    chk({31'h0, err}, 32'h1);
    // Firmware keeps SCSI and drive ports live and polls the rest.
    apb(1'b1, `IAU_IDX_IMR, 8'h83);
    // Port 0 enabled, port 1 not: only port 0 may interrupt.
    apb(1'b1, `IAU_IDX_SER0_CTL, 8'h08);
    ser_byte_done <= 2'h1;
    ser_bus_err <= 2'h2;
    ser_slave_hit <= 2'h2;
    @(posedge clk);
    ser_byte_done <= 2'h0;
    ser_bus_err <= 2'h0;
    ser_slave_hit <= 2'h0;
    rdc(`IAU_IDX_ISR, 8'h40);
    chk({30'h0, cpu_irq1, cpu_irq0}, 32'h0);
    rdc(`IAU_IDX_SER0_STAT, 8'h08);
    rdc(`IAU_IDX_SER1_STAT, 8'h14);
    apb(1'b1, `IAU_IDX_SER0_STAT, 8'h80);
    rdc(`IAU_IDX_SER0_STAT, 8'h80);
    // Port 1 still pending: enabling it now must raise its bit.
    apb(1'b1, `IAU_IDX_SER1_CTL, 8'h08);
    rdc(`IAU_IDX_ISR, 8'h20);
    apb(1'b1, `IAU_IDX_SER1_STAT, 8'h80);
    rdc(`IAU_IDX_ISR, 8'h00);
    // Drive data settles well before its strobe rises.
    drv_rd_req <= 2'h1;
    drv_wr_data <= 16'h3C00;
    repeat (4) @(posedge clk);
    drv_wr_stb <= 2'h2;
    repeat (6) @(posedge clk);
    rdc(`IAU_IDX_ISR, 8'h03);
    chk({30'h0, cpu_irq1, cpu_irq0}, 32'h3);
    rdc(`IAU_IDX_DRV0_CSR, 8'h01);
    rdc(`IAU_IDX_DRV1_CSR, 8'h02);
    rdc(`IAU_IDX_DRV1_IN, 8'h3C);
    apb(1'b1, `IAU_IDX_DRV0_CSR, 8'h01);
    apb(1'b1, `IAU_IDX_DRV0_OUT, 8'hA5);
    chk({30'h0, drv_out_valid}, 32'h1);
    chk({16'h0, drv_out_data}, 32'h00A5);
    apb(1'b1, `IAU_IDX_DRV1_OUT, 8'h5A);
    chk({30'h0, drv_out_valid}, 32'h2);
    chk({16'h0, drv_out_data}, 32'h5AA5);
    apb(1'b1, `IAU_IDX_DRV1_CSR, 8'h02);
    rdc(`IAU_IDX_ISR, 8'h00);
    apb(1'b1, `IAU_IDX_SRCSEL, 8'h01);
    ext_irq_pins <= 2'h1;
    repeat (4) @(posedge clk);
    rdc(`IAU_IDX_GPI, 8'h01);
    rdc(`IAU_IDX_ISR, 8'h01);
    chk({30'h0, cpu_irq1, cpu_irq0}, 32'h1);
    // A reset in mid-run must bring back the quiet defaults; read requests and
    // external pins drop with it, but the port 1 write strobe stays high and is seen as new after release.
    drv_rd_req <= 2'h0;
    ext_irq_pins <= 2'h0;
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    chk({30'h0, cpu_irq1, cpu_irq0}, 32'h0);
    rdc(`IAU_IDX_IMR, `IAU_RST_IMR);
    rdc(`IAU_IDX_SRCSEL, 8'h00);
    rdc(`IAU_IDX_SER1_STAT, 8'h80);
    end_sim();
  end

  // A hang anywhere counts as a mismatch.
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    end_sim();
  end
endmodule : iau_top_tb
